/* rtl/srl_loader.sv */
// Serial register loader: three-wire write-only programming port
`timescale 1ns/100ps
// Overview of operation
// R1 - On each serial clock rise, sample data and shift it into the shifter.
// R2 - On load strobe rise, copy data field to register chosen by address.
// R3 - Host sends data bits D27 to D0 then address A3 to A0, MSB first.
// R4 - Host should return clock, data and strobe low after programming.
// R5 - Every commit to register zero starts calibration, even if unchanged.
// R6 - Doubler-enable bit in register 13 switches the reference doubler.
// R7 - Host keeps strobe low while shifting; commits happen only on rise.
module srl_loader
  import srl_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Programming pins, asynchronous to ref_clk
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic load_strobe,
  // Block outputs
  output logic register_zero_calibration_trigger,
  output logic ref_doubler_enable,
  output logic [DATA_W*NUM_REGS-1:0] reg_image,
  output logic [CNT_W-1:0] bit_count
);

  // Bit count that marks one complete programming word
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(WORD_W);

  // Whole block state; one record keeps the register-and-copy idiom simple
  typedef struct packed {
    logic [2:0] sclk_sync; // Two sync stages plus edge history
    logic [1:0] sdat_sync; // Two sync stages, aligned with clock stage 1
    logic [2:0] le_sync; // Two sync stages plus edge history
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic [NUM_REGS-1:0][DATA_W-1:0] regs; // Register bank, one per address
    logic cal;
    logic dbl;
  } srl_state_s;

  srl_state_s st_ff;
  srl_state_s nxt_st;

  // Rising edge on a synchronised triple; stage 0 is never read here
  function automatic logic rose(input logic [2:0] s);
    rose = s[1] & ~s[2];
  endfunction

  // Address match, shared by the bank decode and the side effects
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] want
  );
    addr_hit = (addr == want);
  endfunction

  logic sclk_rise;
  logic le_rise;
  logic [ADDR_W-1:0] tgt_addr;
  logic [DATA_W-1:0] tgt_data;
  logic [NUM_REGS-1:0] reg_sel;
  logic cal_hit;
  logic dbl_hit;

  // Edge detection after the two synchroniser stages
  assign sclk_rise = rose(st_ff.sclk_sync);
  assign le_rise = rose(st_ff.le_sync);
  // Last bit shifted lands at bit 0, so the address is the low nibble
  assign tgt_addr = st_ff.shift[ADDR_W-1:0];
  assign tgt_data = st_ff.shift[WORD_W-1:ADDR_W];

  // One write select per register of the bank
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_sel
    assign reg_sel[g] = le_rise & addr_hit(tgt_addr, ADDR_W'(g)); // R2
    // A register whose address was not committed keeps its contents
    chk_bank_select: assert property ( // R2
      @(posedge ref_clk) disable iff (rst)
      !(le_rise && tgt_addr == ADDR_W'(g)) |=> $stable(st_ff.regs[g]))
      else $error("unaddressed register changed");
  end

  // Side effects of a commit, decoded from the same address
  assign cal_hit = le_rise & addr_hit(tgt_addr, CAL_ADDR);
  assign dbl_hit = le_rise & addr_hit(tgt_addr, DBL_ADDR);

  // Next state; data stage sdat_sync[1] aligns with sclk_sync[1]
  always_comb
  begin
    nxt_st = st_ff;
    // Calibration start lasts one enabled cycle unless armed again
    nxt_st.cal = 1'h0;
    nxt_st.sclk_sync = {st_ff.sclk_sync[1:0], serial_shift_clock};
    nxt_st.sdat_sync = {st_ff.sdat_sync[0], serial_data_in};
    nxt_st.le_sync = {st_ff.le_sync[1:0], load_strobe};
    if (sclk_rise)
    begin
      // Older bits fall off the top, so extra leading bits are harmless
      nxt_st.shift = {st_ff.shift[WORD_W-2:0], st_ff.sdat_sync[1]}; // R1 R3
      if (st_ff.cnt != CNT_MAX)
      begin
        nxt_st.cnt = st_ff.cnt + 6'h01;
      end
    end
    // Commit only on strobe rise; clock edges alone never write
    for (int r = 0; r < NUM_REGS; r++)
    begin
      if (reg_sel[r]) // R7
      begin
        nxt_st.regs[r] = tgt_data; // R2
      end
    end
    if (le_rise)
    begin
      nxt_st.cnt = CNT_RST;
    end
    // Same value again still restarts calibration: no compare with old
    if (cal_hit)
    begin
      nxt_st.cal = 1'h1; // R5
    end
    if (dbl_hit)
    begin
      nxt_st.dbl = tgt_data[DBL_BIT]; // R6
    end
  end

  // Single state register; clock enable freezes everything, syncs too,
  // so pin edges that start and end while it is low are not seen
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign register_zero_calibration_trigger = st_ff.cal;
  assign ref_doubler_enable = st_ff.dbl;
  assign reg_image = st_ff.regs;
  assign bit_count = st_ff.cnt;

  // Assertions on shifting and counting
  chk_shift_on_edge: assert property ( // R1
    @(posedge ref_clk) disable iff (rst)
    (clk_en && sclk_rise) |=>
      st_ff.shift[0] == $past(st_ff.sdat_sync[1]))
    else $error("shift register missed a serial bit");

  chk_cnt_step: assert property ( // R1
    @(posedge ref_clk) disable iff (rst)
    (clk_en && sclk_rise && !le_rise && bit_count != CNT_MAX) |=>
      bit_count == $past(bit_count) + 6'h01)
    else $error("bit count did not follow a serial edge");

  // Assertions on commits
  chk_commit_data: assert property ( // R2
    @(posedge ref_clk) disable iff (rst)
    (clk_en && le_rise) |=>
      st_ff.regs[$past(tgt_addr)] == $past(tgt_data))
    else $error("load did not commit shifted data");

  chk_cal_start: assert property ( // R5
    @(posedge ref_clk) disable iff (rst)
    (clk_en && le_rise && tgt_addr == CAL_ADDR) |=>
      register_zero_calibration_trigger)
    else $error("register zero write did not start calibration");

  chk_cal_cause: assert property ( // R5
    @(posedge ref_clk) disable iff (rst)
    $rose(register_zero_calibration_trigger) |->
      $past(clk_en) && $past(le_rise) && $past(tgt_addr) == CAL_ADDR)
    else $error("calibration started without register zero write");

  chk_cal_pulse: assert property ( // R5
    @(posedge ref_clk) disable iff (rst)
    (clk_en && register_zero_calibration_trigger) |=>
      !register_zero_calibration_trigger)
    else $error("calibration start lasted more than one cycle");

  chk_dbl_follow: assert property ( // R6
    @(posedge ref_clk) disable iff (rst)
    (clk_en && le_rise && tgt_addr == DBL_ADDR) |=>
      ref_doubler_enable == $past(tgt_data[DBL_BIT]))
    else $error("doubler enable did not follow register 13");

  chk_dbl_stable: assert property ( // R6
    @(posedge ref_clk) disable iff (rst)
    !(le_rise && tgt_addr == DBL_ADDR) |=> $stable(ref_doubler_enable))
    else $error("doubler enable changed without a commit");

  chk_no_commit: assert property ( // R7
    @(posedge ref_clk) disable iff (rst)
    !le_rise |=> $stable(st_ff.regs))
    else $error("register changed without load strobe rise");

  chk_cnt_clear: assert property ( // R2
    @(posedge ref_clk) disable iff (rst)
    (clk_en && le_rise) |=> bit_count == CNT_RST)
    else $error("bit count not cleared on commit");

  cov_cal_write: cover property (
    @(posedge ref_clk) disable iff (rst)
    register_zero_calibration_trigger);
  cov_dbl_on: cover property (
    @(posedge ref_clk) disable iff (rst) $rose(ref_doubler_enable));
  cov_full_word: cover property (
    @(posedge ref_clk) disable iff (rst)
    le_rise && bit_count == FULL_CNT);
  cov_en_freeze: cover property (
    @(posedge ref_clk) disable iff (rst)
    !clk_en ##1 clk_en);
endmodule

/* rtl/srl_pkg.sv */
// Constants for the serial register loader
package srl_pkg;
  localparam int DATA_W = 28;
  localparam int ADDR_W = 4;
  localparam int WORD_W = DATA_W + ADDR_W;
  localparam int NUM_REGS = 16;
  localparam int CNT_W = 6;
  localparam logic [ADDR_W-1:0] CAL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] DBL_ADDR = 4'hD;
  localparam int DBL_BIT = 0;
  localparam logic [DATA_W-1:0] REG_RST = 28'h0000000;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  // Least load-strobe high time, ns, and its cycle count at 200 MHz
  localparam int CLK_PERIOD_NS = 5;
  localparam int LOAD_PULSE_NS = 25;
  localparam int LOAD_PULSE_CYC =
    (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One-cycle calibration start pulse width
  localparam int CAL_PULSE_CYC = 1;
endpackage

/* tb/srl_host_model.sv */
// Host model driving the three programming pins
`timescale 1ns/100ps
module srl_host_model
(
  // Clock
  input wire logic ref_clk,
  // Programming pins
  output logic sclk,
  output logic sdat,
  output logic load
);
  initial
  begin
    sclk = 1'h0;
    sdat = 1'h0;
    load = 1'h0;
  end
  // One word, 160 ns serial clock; data moves only while clock is low
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      sdat <= w[i];
      repeat (16) @(posedge ref_clk);
      sclk <= 1'h1;
      repeat (16) @(posedge ref_clk);
      sclk <= 1'h0;
    end
    repeat (8) @(posedge ref_clk);
    load <= 1'h1;
    repeat (8) @(posedge ref_clk);
    load <= 1'h0;
    sdat <= 1'h0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the serial register loader
`timescale 1ns/100ps
`define CHK(n,e,a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  import srl_pkg::*;
  logic ref_clk, rst, sclk, sdat, load, cal, dbl, dbl_exp;
  logic en, hit, cal_next;
  logic [DATA_W*NUM_REGS-1:0] img;
  logic [CNT_W-1:0] cnt, cnt_q;
  logic [WORD_W-1:0] w;
  logic [WORD_W-1:0] notes[$];
  int fail_count, check_count;
  srl_loader dut(.ref_clk(ref_clk), .rst(rst), .clk_en(en),
    .serial_shift_clock(sclk), .serial_data_in(sdat), .load_strobe(load),
    .register_zero_calibration_trigger(cal), .ref_doubler_enable(dbl),
    .reg_image(img), .bit_count(cnt));
  srl_host_model host(.ref_clk(ref_clk), .sclk(sclk), .sdat(sdat),
    .load(load));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Random freeze of the clock enable while the pins are idle
  task wr(input logic [3:0] a, input logic [27:0] d);
    en <= 1'h0;
    repeat (1 + $urandom % 6) @(posedge ref_clk);
    en <= 1'h1;
    notes.push_back({d, a});
    host.send({d, a});
  endtask
  // Sampled mid-cycle so registered outputs have settled
  always @(negedge ref_clk)
  begin
    cnt_q <= cnt;
    hit = !rst && cnt_q != 6'h00 && cnt == 6'h00 && notes.size() > 0;
    cal_next <= hit;
    if (cal_next)
      `CHK("cal width", 1'h0, cal)
    if (hit)
    begin
      w = notes.pop_front();
      if (w[3:0] == DBL_ADDR)
        dbl_exp = w[4+DBL_BIT];
      `CHK("count", 6'h20, cnt_q)
      `CHK("reg", w[31:4], img[w[3:0]*DATA_W +: DATA_W])
      `CHK("cal", w[3:0] == CAL_ADDR, cal)
      `CHK("dbl", dbl_exp, dbl)
    end
  end
  // Watchdog well past the expected run
  initial
  begin
    #300000;
    fail_count++;
    close_out();
  end
  initial
  begin
    rst = 1'h1;
    en = 1'h1;
    dbl_exp = 1'h0;
    cnt_q = 6'h00;
    cal_next = 1'h0;
    void'($urandom(32'hEEE5));
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    for (int a = 0; a < NUM_REGS; a++)
      wr(a[3:0], DATA_W'($urandom));
    $display("test all addresses done");
    wr(CAL_ADDR, 28'h0000ABC);
    wr(CAL_ADDR, 28'h0000ABC);
    $display("test repeated calibration done");
    wr(DBL_ADDR, 28'h0000001);
    wr(4'h5, DATA_W'($urandom));
    wr(DBL_ADDR, 28'h0000000);
    $display("test doubler done");
    repeat (20) @(posedge ref_clk);
    `CHK("pending notes", 0, notes.size())
    close_out();
  end
endmodule
